// ---- host_model.sv ----
// host-side model driving the wake pin, direct inputs and register bits
`timescale 1ns/1ps
module host_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // requests from the bench
  input  wire logic       want_wake,
  input  wire logic [1:0] want_in,
  input  wire logic [7:0] want_on,
  input  wire logic       want_stay,
  // pins and register bits toward the device
  output logic            wake_pin,
  output logic [1:0]      direct_input_pins,
  output logic [7:0]      channel_on_bits,
  output logic            stay_active_bit
);
  // writes only after wake is seen high, since registers reset while it is low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wake_pin          <= 1'b0;
      direct_input_pins <= 2'h0;
      channel_on_bits   <= 8'h00;
      stay_active_bit   <= 1'b0;
    end else begin
      wake_pin          <= want_wake;
      direct_input_pins <= want_in;
      channel_on_bits   <= (wake_pin && want_wake) ? want_on : 8'h00;
      stay_active_bit   <= wake_pin && want_wake && want_stay;
    end
  end
endmodule

// ---- mode_delay.sv ----
// transition latency counter: asserts done after a fixed number of enable cycles
`timescale 1ns/1ps
module mode_delay #(
  parameter int CYCLES = 10,
  parameter int CNT_W  = 8
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // control
  input  wire logic start,
  input  wire logic run,
  output logic      done
);
  logic [CNT_W-1:0] cnt_r;

  initial begin
    if (CYCLES < 1 || CYCLES >= (1 << CNT_W)) $error("mode_delay: CYCLES out of range");
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !run) begin
      cnt_r <= '0;
    end else if (start) begin
      cnt_r <= CNT_W'(CYCLES);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !run || start) begin
      done <= 1'b0;
    end else begin
      done <= (cnt_r == CNT_W'(1));
    end
  end
endmodule

// ---- operation_mode_controller.sv ----
// operation-mode state machine with channel and register-access gating
// Functional notes
// (R1) exactly one of Sleep, Idle, Active, fallback is held at all times
// (R2) transitions depend only on wake pin, inputs, on bits, stay bit, pwm enables; leaving Sleep here also needs a supply good
// (R3) turn-on request outside Active goes to Active or fallback by wake pin
// (R4) Active drives loads; turn-on waits for the mode transition latency
// (R5) Sleep: channels off, registers reset, no SPI
// (R6) Idle: channels off, no diagnosis; SPI works only with logic supply good
// (R7) Idle keeps the latched channel error bits
// (R8) enter Active with wake high and any input high or any on bit set
// (R9) stay bit 0: leave Active for Idle when inputs low and on bits clear
// (R10) stay bit 1: remain Active with all inputs low
// (R11) a high input enters Active even with empty input maps
// (R12) power-up needs a supply plus input or wake high; power-on on supply good
// (R13) fallback: channels follow inputs, SPI read-only, registers reset on low logic supply
// (R14) Active with logic undervoltage: inputs only, no SPI; power undervoltage blocks channels
// (R15) wake low and an input high enters fallback, driving the mapped channel
// (R16) fallback reports mode field 01
// (R17) registers reset on logic undervoltage, wake low or soft reset; errors survive soft reset
// (R18) wake low and all inputs low enters Sleep from any state
// (R19) host raises wake before SPI writes and expects delayed turn-on
`timescale 1ns/1ps
module operation_mode_controller
  import opmode_pkg::*;
#(
  parameter int NCH = opmode_pkg::NUM_CH,
  parameter int NIN = opmode_pkg::NUM_IN
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // pins
  input  wire logic                 wake_pin,
  input  wire logic [NIN-1:0]       direct_input_pins,
  // register bits from the SPI register file
  input  wire logic [NCH-1:0]       channel_on_bits,
  input  wire logic                 stay_active_bit,
  input  wire logic                 pwm_gen0_enable,
  input  wire logic                 pwm_gen1_enable,
  input  wire logic [NCH-1:0]       input_map_zero,
  input  wire logic [NCH-1:0]       input_map_one,
  input  wire logic                 soft_reset_command,
  input  wire logic [NCH-1:0]       pwm_channel_sel,
  // supply monitors
  input  wire opmode_pkg::supply_s  supply,
  // status and gating
  output logic [1:0]                mode_status,
  output logic                      power_on,
  output logic [NCH-1:0]            channel_drive,
  output opmode_pkg::access_s       access
);
  import opmode_pkg::*;

  initial begin
    if (NIN < 1 || NCH < NIN) $error("operation_mode_controller: bad channel or input count");
  end

  opmode_e state_r;
  opmode_e state_nxt;
  opmode_e prev_r;

  // request decode
  wire any_in      = |direct_input_pins;
  wire any_on      = |channel_on_bits;
  // pwm enables only keep Active alive while any on bit is set
  wire pwm_hold    = (pwm_gen0_enable | pwm_gen1_enable) & any_on;
  wire go_sleep    = !wake_pin && !any_in;                                // see (R18)
  wire go_fallback = !wake_pin && any_in;                                 // see (R15)
  wire go_active   = wake_pin && (any_in || any_on);                      // see (R8) (R11)
  wire hold_active = wake_pin && (stay_active_bit || any_in || any_on || pwm_hold); // see (R9) (R10)
  wire logic_good  = supply.vdd_good && !supply.vdd_uv;
  wire power_good  = supply.vs_good && !supply.vs_uv;
  wire pwr_cond    = (supply.vs_good || supply.vdd_good) && (any_in || wake_pin); // see (R12)

  // next state; wake, inputs, on bits, stay bit and pwm enables decide, and leaving Sleep also needs a supply good  see (R2)
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_SLEEP: begin
        if (pwr_cond && go_fallback) begin
          state_nxt = ST_FALLBACK;                                        // see (R3)
        end else if (pwr_cond && go_active) begin
          state_nxt = ST_ACTIVE;                                          // see (R3)
        end else if (pwr_cond && wake_pin) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (go_sleep) begin
          state_nxt = ST_SLEEP;
        end else if (go_fallback) begin
          state_nxt = ST_FALLBACK;
        end else if (go_active) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (go_sleep) begin
          state_nxt = ST_SLEEP;
        end else if (go_fallback) begin
          state_nxt = ST_FALLBACK;
        end else if (!hold_active) begin
          state_nxt = ST_IDLE;                                            // see (R9)
        end
      end
      ST_FALLBACK: begin
        if (go_sleep) begin
          state_nxt = ST_SLEEP;
        end else if (go_active) begin
          state_nxt = ST_ACTIVE;
        end else if (wake_pin) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_SLEEP;                                      // see (R1)
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_SLEEP;
      prev_r  <= ST_SLEEP;
    end else begin
      state_r <= state_nxt;                                               // see (R1)
      prev_r  <= state_r;
    end
  end

  // turn-on waits for the transition into a driving mode
  wire entered = (state_r != prev_r) &&
                 (state_r == ST_ACTIVE || state_r == ST_FALLBACK);
  wire driving = (state_r == ST_ACTIVE || state_r == ST_FALLBACK);
  logic settled;

  mode_delay #(
    .CYCLES (XFER_CYC),
    .CNT_W  (XFER_CNT_W)
  ) u_delay (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (entered),
    .run     (driving),
    .done    (settled)
  );

  logic ready_r;
  always_ff @(posedge clk) begin
    if (sys_rst || !driving || entered) begin
      ready_r <= 1'b0;
    end else if (settled) begin
      ready_r <= 1'b1;                                                    // see (R4)
    end
  end

  // channel selection
  logic [NCH-1:0] in_mapped;
  logic [NCH-1:0] pin_direct;
  always_comb begin
    in_mapped  = '0;
    pin_direct = '0;
    for (int i = 0; i < NIN; i++) begin
      pin_direct[i] = direct_input_pins[i];
    end
    in_mapped = (input_map_zero & {NCH{direct_input_pins[0]}});
    if (NIN > 1) begin
      in_mapped = in_mapped | (input_map_one & {NCH{direct_input_pins[NIN-1]}});
    end
  end

  wire [NCH-1:0] spi_req  = channel_on_bits | pwm_channel_sel & channel_on_bits;
  wire [NCH-1:0] act_sel  = logic_good ? (spi_req | in_mapped) : pin_direct; // see (R14)
  wire [NCH-1:0] fb_sel   = pin_direct;                                   // see (R13) (R15)
  // blank while the state changes, so the old mode's drive never leaks into the new one
  wire           changing = (state_nxt != state_r) || entered;
  wire [NCH-1:0] drive_nxt =
      (!ready_r || changing || !power_good) ? '0 :                        // see (R14) (R4)
      (state_r == ST_ACTIVE)    ? act_sel :
      (state_r == ST_FALLBACK)  ? fb_sel : '0;                            // see (R5) (R6)

  // register access gating
  wire in_sleep  = (state_r == ST_SLEEP);
  wire in_idle   = (state_r == ST_IDLE);
  wire in_active = (state_r == ST_ACTIVE);
  wire in_fb     = (state_r == ST_FALLBACK);
  wire regs_rst_nxt = in_sleep || !logic_good || !wake_pin || soft_reset_command; // see (R17) (R5)
  // errors clear only on logic supply loss or in Sleep, never in Idle with logic good or by soft reset
  wire err_rst_nxt  = in_sleep || !logic_good;                            // see (R7) (R17)
  wire spi_en_nxt   = logic_good && !in_sleep;                            // see (R6) (R13) (R14)
  wire ro_nxt       = in_fb;                                              // see (R13)
  wire diag_nxt     = in_active && logic_good;                            // see (R6)

  logic [1:0] mode_nxt;
  assign mode_nxt = in_fb     ? MODE_FALLBACK :                           // see (R16)
                    in_active ? MODE_ACTIVE   :
                    in_idle   ? MODE_IDLE     : MODE_SLEEP;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      channel_drive <= '0;
      mode_status   <= MODE_SLEEP;
      power_on      <= 1'b0;
      access        <= '{spi_enable: 1'b0, spi_read_only: 1'b0, regs_reset: 1'b1,
                         err_reset: 1'b1, diag_enable: 1'b0};
    end else begin
      channel_drive <= drive_nxt;
      mode_status   <= mode_nxt;
      power_on      <= supply.vs_good || supply.vdd_good;                 // see (R12)
      access        <= '{spi_enable: spi_en_nxt, spi_read_only: ro_nxt,
                         regs_reset: regs_rst_nxt, err_reset: err_rst_nxt,
                         diag_enable: diag_nxt};
    end
  end

  // checks
  one_state_a: assert property (@(posedge clk) disable iff (sys_rst)
    $onehot(state_r)) else $error("mode state not one-hot"); // see (R1)
  sleep_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(state_r) == ST_SLEEP |-> channel_drive == '0 && access.regs_reset && !access.spi_enable)
    else $error("sleep leaves channels or spi alive"); // see (R5)
  idle_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(state_r) == ST_IDLE |-> channel_drive == '0 && !access.diag_enable)
    else $error("idle drives channels"); // see (R6)
  idle_err_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(state_r) == ST_IDLE && $past(logic_good) |-> !access.err_reset)
    else $error("idle clears error latches"); // see (R7)
  enter_act_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == ST_IDLE && go_active |=> state_r == ST_ACTIVE)
    else $error("active not entered"); // see (R8)
  leave_act_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == ST_ACTIVE && wake_pin && !stay_active_bit && !any_in && !any_on
    |=> state_r == ST_IDLE) else $error("active not left"); // see (R9)
  stay_act_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == ST_ACTIVE && wake_pin && stay_active_bit |=> state_r == ST_ACTIVE)
    else $error("stay bit ignored"); // see (R10)
  enter_fb_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_r != ST_SLEEP && go_fallback |=> state_r == ST_FALLBACK ##1 mode_status == MODE_FALLBACK)
    else $error("fallback not entered or reported"); // see (R15) (R16)
  fb_ro_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(state_r) == ST_FALLBACK && $past(logic_good) |-> access.spi_read_only && access.spi_enable)
    else $error("fallback spi not read-only"); // see (R13)
  soft_rst_a: assert property (@(posedge clk) disable iff (sys_rst)
    soft_reset_command && logic_good && !in_sleep |=> access.regs_reset && !access.err_reset)
    else $error("soft reset handling wrong"); // see (R17)
  sleep_go_a: assert property (@(posedge clk) disable iff (sys_rst)
    go_sleep |=> state_r == ST_SLEEP) else $error("sleep not entered"); // see (R18)
  delay_on_a: assert property (@(posedge clk) disable iff (sys_rst)
    entered |-> channel_drive == '0 ##1 channel_drive == '0)
    else $error("turn-on ignores transition latency"); // see (R4)
endmodule

// ---- operation_mode_controller_tb.sv ----
// self-checking bench for the operation-mode controller
`timescale 1ns/1ps
module operation_mode_controller_tb;
  import opmode_pkg::*;
  typedef struct packed {
    logic       wake;
    logic [1:0] din;
    logic [7:0] on;
    logic       stay;
    logic [1:0] mode;
    logic [7:0] drive;
  } row_s;
  logic       clk, sys_rst, want_wake, want_stay, soft_reset_command;
  logic       wake_pin, stay_active_bit, power_on;
  logic [1:0] want_in, direct_input_pins, mode_status;
  logic [7:0] want_on, channel_on_bits, input_map_zero, channel_drive;
  supply_s    supply;
  access_s    access;
  int         miscompares, checked, cycles;
  row_s       rows [10];

  host_model host (.clk(clk), .sys_rst(sys_rst), .want_wake(want_wake), .want_in(want_in),
    .want_on(want_on), .want_stay(want_stay), .wake_pin(wake_pin),
    .direct_input_pins(direct_input_pins), .channel_on_bits(channel_on_bits),
    .stay_active_bit(stay_active_bit));
  operation_mode_controller dut (.clk(clk), .sys_rst(sys_rst), .wake_pin(wake_pin),
    .direct_input_pins(direct_input_pins), .channel_on_bits(channel_on_bits),
    .stay_active_bit(stay_active_bit), .pwm_gen0_enable(1'b0), .pwm_gen1_enable(1'b0),
    .input_map_zero(input_map_zero), .input_map_one(8'h00),
    .soft_reset_command(soft_reset_command), .pwm_channel_sel(8'h00), .supply(supply),
    .mode_status(mode_status), .power_on(power_on), .channel_drive(channel_drive),
    .access(access));

  task automatic results;
    if (miscompares == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // twenty cycles covers the mode change plus the turn-on latency
  task automatic apply(logic w, logic [1:0] d, logic [7:0] o, logic s);
    want_wake <= w;
    want_in   <= d;
    want_on   <= o;
    want_stay <= s;
    repeat (20) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    sys_rst = 1'b1;
    want_wake = 1'b0;
    want_in = 2'h0;
    want_on = 8'h00;
    want_stay = 1'b0;
    soft_reset_command = 1'b0;
    input_map_zero = 8'h00;
    supply = 4'hc;
    rows = '{'{1'b1, 2'h0, 8'h00, 1'b0, MODE_IDLE, 8'h00},
             '{1'b1, 2'h0, 8'h05, 1'b0, MODE_ACTIVE, 8'h05},
             '{1'b1, 2'h0, 8'h00, 1'b0, MODE_IDLE, 8'h00},
             '{1'b1, 2'h1, 8'h00, 1'b0, MODE_ACTIVE, 8'h00},
             '{1'b1, 2'h0, 8'h00, 1'b1, MODE_ACTIVE, 8'h00},
             '{1'b0, 2'h2, 8'h00, 1'b0, MODE_FALLBACK, 8'h02},
             '{1'b0, 2'h0, 8'h00, 1'b0, MODE_SLEEP, 8'h00},
             '{1'b0, 2'h1, 8'h00, 1'b0, MODE_FALLBACK, 8'h01},
             '{1'b0, 2'h0, 8'h00, 1'b0, MODE_SLEEP, 8'h00},
             '{1'b1, 2'h0, 8'h80, 1'b0, MODE_ACTIVE, 8'h80}};
    repeat (6) @(posedge clk);
    chk("reset mode", MODE_SLEEP, mode_status);
    chk("reset drive", 8'h00, channel_drive);
    chk("reset access", 8'h06, access);
    sys_rst <= 1'b0;
    // rows walk idle, active, stay, fallback and sleep transitions
    foreach (rows[i]) begin
      apply(rows[i].wake, rows[i].din, rows[i].on, rows[i].stay);
      chk("row mode", rows[i].mode, mode_status);
      chk("row drive", rows[i].drive, channel_drive);
    end
    apply(1'b1, 2'h0, 8'h00, 1'b0);
    chk("idle access", 8'h10, access);
    soft_reset_command <= 1'b1;
    repeat (4) @(posedge clk);
    chk("soft reset access", 8'h14, access);
    soft_reset_command <= 1'b0;
    input_map_zero <= 8'h10;
    apply(1'b1, 2'h1, 8'h00, 1'b0);
    chk("mapped drive", 8'h10, channel_drive);
    supply <= 4'hd;
    apply(1'b1, 2'h1, 8'h0f, 1'b0);
    chk("low logic drive", 8'h01, channel_drive);
    chk("low logic spi", 8'h00, access.spi_enable);
    chk("low logic regs", 8'h01, access.regs_reset);
    supply <= 4'he;
    apply(1'b1, 2'h0, 8'h0f, 1'b0);
    chk("low power drive", 8'h00, channel_drive);
    supply <= 4'h0;
    apply(1'b0, 2'h0, 8'h00, 1'b0);
    chk("sleep spi", 8'h00, access.spi_enable);
    chk("sleep regs", 8'h01, access.regs_reset);
    apply(1'b1, 2'h0, 8'h01, 1'b0);
    chk("unpowered mode", MODE_SLEEP, mode_status);
    chk("unpowered flag", 8'h00, power_on);
    supply <= 4'hc;
    // drive must wait out the transition before turning on
    repeat (5) @(posedge clk);
    chk("early drive", 8'h00, channel_drive);
    repeat (20) @(posedge clk);
    chk("powered flag", 8'h01, power_on);
    chk("powered mode", MODE_ACTIVE, mode_status);
    chk("late drive", 8'h01, channel_drive);
    results();
  end
endmodule

// ---- opmode_pkg.sv ----
// constants and carrier types for the operation-mode controller
package opmode_pkg;
  localparam int NUM_CH      = 8;
  localparam int NUM_IN      = 2;
  localparam int MODE_W      = 2;
  // mode status field encodings
  localparam logic [1:0] MODE_SLEEP    = 2'h0;
  localparam logic [1:0] MODE_FALLBACK = 2'h1;
  localparam logic [1:0] MODE_IDLE     = 2'h2;
  localparam logic [1:0] MODE_ACTIVE   = 2'h3;
  // mode transition latency
  localparam int XFER_NS     = 80;
  localparam int CLK_NS      = 8;
  localparam int XFER_CYC    = (XFER_NS + CLK_NS - 1) / CLK_NS;
  localparam int XFER_CNT_W  = 8;

  typedef enum logic [3:0] {
    ST_SLEEP    = 4'h1,
    ST_IDLE     = 4'h2,
    ST_ACTIVE   = 4'h4,
    ST_FALLBACK = 4'h8
  } opmode_e;

  // supply monitor indications
  typedef struct packed {
    logic vs_good;
    logic vdd_good;
    logic vs_uv;
    logic vdd_uv;
  } supply_s;

  // gating presented to the rest of the device
  typedef struct packed {
    logic spi_enable;
    logic spi_read_only;
    logic regs_reset;
    logic err_reset;
    logic diag_enable;
  } access_s;
endpackage
